// >>> rtl/buck_rail_map.svh
// Register offsets, field positions and reset values of the buck rail block
`ifndef BUCK_RAIL_MAP_SVH
`define BUCK_RAIL_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RAIL_2V1_CTRL_ADDR 8'h38
`define RAIL_1V5_CTRL_ADDR 8'h39
`define RAIL_2V1_CUR_ADDR 8'h3a
`define RAIL_1V5_CUR_ADDR 8'h3b
`define FAULT_STAT_ADDR 8'h3f

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RUN_MSB 2
`define RUN_LSB 0
`define EXIT_MSB 5
`define EXIT_LSB 3
`define LEVEL_MSB 7
`define LEVEL_LSB 6
`define CTRL_RESET 8'h07
`define RUN_RESET 3'h7
`define EXIT_RESET 3'h0
`define LEVEL_RESET 2'h0
`define LEVEL_1V6_CODE 2'h1
`define RAIL_COUNT 2

`endif

// >>> rtl/buck_rail_pkg.sv
// Types shared by the buck rail control block
package buck_rail_pkg;

  // Run mode codes; codes below 4 are reserved
  typedef enum logic [2:0] {
    MODE_OFF = 3'h4,
    MODE_PFM = 3'h5,
    MODE_SKIP = 3'h6,
    MODE_PWM = 3'h7
  } run_mode_e;

  typedef logic [7:0] reg_t;
  typedef logic [2:0] mode_t;

  // A code names a real mode only when its top bit is set
  function automatic logic mode_is_valid(input mode_t code);
    mode_is_valid = code[2];
  endfunction : mode_is_valid

endpackage : buck_rail_pkg

// >>> rtl/rail_if.sv
// Signals between the register bank and one rail controller
interface rail_if;
  import buck_rail_pkg::*;

  logic wr;
  mode_t run_wdata;
  mode_t exit_wdata;
  logic exit_pulse;
  logic overcurrent;
  logic fault_clr;
  mode_t run_mode;
  mode_t exit_mode;
  logic discharge;
  logic fault;

  modport bank (
    output wr, run_wdata, exit_wdata, exit_pulse, overcurrent, fault_clr,
    input run_mode, exit_mode, discharge, fault
  );
  modport rail (
    input wr, run_wdata, exit_wdata, exit_pulse, overcurrent, fault_clr,
    output run_mode, exit_mode, discharge, fault
  );
endinterface : rail_if

// >>> rtl/rail_ctrl.sv
// Mode, standby exit, discharge and fault logic of one buck rail
`include "buck_rail_map.svh"
module rail_ctrl
  import buck_rail_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to the register bank
  rail_if.rail bus
);

  // ----------------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------------
  wire logic take_exit;
  wire logic take_write;
  wire mode_t next_run;
  wire logic next_fault;

  // A host write of a valid code wins over a simultaneous standby exit copy
  assign take_write = bus.wr && mode_is_valid(bus.run_wdata);
  assign take_exit = bus.exit_pulse && mode_is_valid(bus.exit_mode);
  // Reserved codes leave the running mode untouched
  assign next_run = take_write ? bus.run_wdata :
                    take_exit ? bus.exit_mode : bus.run_mode;
  // A new over-current beats a clear in the same cycle
  assign next_fault = bus.overcurrent | (bus.fault & ~bus.fault_clr);

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  // Discharge tracks the mode register so it never lags a shutdown
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus.run_mode <= `RUN_RESET;
      bus.exit_mode <= `EXIT_RESET;
      bus.discharge <= 1'b0;
      bus.fault <= 1'b0;
    end else begin
      bus.run_mode <= next_run;
      bus.exit_mode <= bus.wr ? bus.exit_wdata : bus.exit_mode;
      bus.discharge <= (next_run == MODE_OFF);
      bus.fault <= next_fault;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_run_legal;
    @(posedge clk) disable iff (!nrst)
      mode_is_valid(bus.run_mode);
  endproperty
  a_run_legal: assert property (p_run_legal)
    else $error("run mode holds a reserved code");

  property p_exit_copy;
    @(posedge clk) disable iff (!nrst)
      (bus.exit_pulse && bus.exit_mode[2] && !bus.wr)
        |=> bus.run_mode == $past(bus.exit_mode);
  endproperty
  a_exit_copy: assert property (p_exit_copy)
    else $error("standby exit mode not copied");

  property p_host_write;
    @(posedge clk) disable iff (!nrst)
      (bus.wr && bus.run_wdata[2]) |=> bus.run_mode == $past(bus.run_wdata);
  endproperty
  a_host_write: assert property (p_host_write)
    else $error("host mode write not applied");

  property p_reserved_kept;
    @(posedge clk) disable iff (!nrst)
      (bus.wr && !bus.run_wdata[2] && !bus.exit_pulse)
        |=> $stable(bus.run_mode);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept)
    else $error("reserved mode code changed the rail");

  property p_discharge;
    @(posedge clk) disable iff (!nrst)
      bus.discharge == (bus.run_mode == MODE_OFF);
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("discharge does not follow shutdown");

  property p_fault_set;
    @(posedge clk) disable iff (!nrst)
      bus.overcurrent |=> bus.fault;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("over-current did not raise the fault flag");

endmodule : rail_ctrl

// >>> rtl/buck_rail_mode_control.sv
// Register bank and top level of the two-rail buck mode control
`include "buck_rail_map.svh"
module buck_rail_mode_control
  import buck_rail_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register access from the serial front end
  input wire buck_rail_pkg::reg_t reg_addr,
  input wire logic reg_wr,
  input wire buck_rail_pkg::reg_t reg_wdata,
  input wire logic reg_rd,
  output buck_rail_pkg::reg_t reg_rdata,
  // System pins and analog status
  input wire logic standby_exit_pin,
  input wire logic gps_core_rail_1v3,
  input wire logic overcurrent_2v1,
  input wire logic overcurrent_1v5,
  // Current measurement results
  input wire logic adc_valid,
  input wire logic adc_rail,
  input wire buck_rail_pkg::reg_t adc_data,
  // Rail controls
  output buck_rail_pkg::mode_t rail_2v1_run_mode,
  output buck_rail_pkg::mode_t rail_1v5_run_mode,
  output logic rail_1v5_level_1v6,
  output logic discharge_2v1,
  output logic discharge_1v5,
  // Faults
  output logic rail_2v1_overcurrent_flag,
  output logic rail_1v5_overcurrent_flag,
  output logic regulator_fault_irq
);
  import buck_rail_pkg::*;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input reg_t addr, input reg_t target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  localparam reg_t CTRL_ADDR [`RAIL_COUNT] = '{`RAIL_2V1_CTRL_ADDR,
                                               `RAIL_1V5_CTRL_ADDR};

  wire logic wr_1v5;
  wire logic rd_stat;
  wire logic exit_pulse;
  wire logic ocp [`RAIL_COUNT];
  logic exit_pin_q;
  logic [1:0] level_1v5;
  reg_t current_2v1;
  reg_t current_1v5;
  reg_t next_rdata;

  assign wr_1v5 = reg_wr && addr_hit(reg_addr, `RAIL_1V5_CTRL_ADDR);
  assign rd_stat = reg_rd && addr_hit(reg_addr, `FAULT_STAT_ADDR);
  // Copy only once per assertion of the pin, not every cycle it is held
  assign exit_pulse = standby_exit_pin && !exit_pin_q;
  assign ocp[0] = overcurrent_2v1;
  assign ocp[1] = overcurrent_1v5;

  // ----------------------------------------------------------------------
  // Rail controllers
  // ----------------------------------------------------------------------
  rail_if rif [`RAIL_COUNT] ();

  for (genvar g = 0; g < `RAIL_COUNT; g++) begin : g_rail
    // Each rail sees writes only to its own control register
    assign rif[g].wr = reg_wr && addr_hit(reg_addr, CTRL_ADDR[g]);
    assign rif[g].run_wdata = reg_wdata[`RUN_MSB:`RUN_LSB];
    assign rif[g].exit_wdata = reg_wdata[`EXIT_MSB:`EXIT_LSB];
    assign rif[g].exit_pulse = exit_pulse;
    assign rif[g].overcurrent = ocp[g];
    assign rif[g].fault_clr = rd_stat;
    rail_ctrl u_rail (
      .clk(clk),
      .nrst(nrst),
      .bus(rif[g])
    );
  end

  assign rail_2v1_run_mode = rif[0].run_mode;
  assign rail_1v5_run_mode = rif[1].run_mode;
  assign discharge_2v1 = rif[0].discharge;
  assign discharge_1v5 = rif[1].discharge;
  assign rail_2v1_overcurrent_flag = rif[0].fault;
  assign rail_1v5_overcurrent_flag = rif[1].fault;
  // Both flags share one interrupt; software reads status to tell them apart
  assign regulator_fault_irq = rif[0].fault | rif[1].fault;

  // ----------------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------------
  // Unmapped addresses read as zero; 2.1 V level bits are always zero
  always_comb begin
    next_rdata = 8'h00;
    if (addr_hit(reg_addr, `RAIL_2V1_CTRL_ADDR)) begin
      next_rdata = {2'h0, rif[0].exit_mode, rif[0].run_mode};
    end else if (addr_hit(reg_addr, `RAIL_1V5_CTRL_ADDR)) begin
      next_rdata = {level_1v5, rif[1].exit_mode, rif[1].run_mode};
    end else if (addr_hit(reg_addr, `RAIL_2V1_CUR_ADDR)) begin
      next_rdata = current_2v1;
    end else if (addr_hit(reg_addr, `RAIL_1V5_CUR_ADDR)) begin
      next_rdata = current_1v5;
    end else if (addr_hit(reg_addr, `FAULT_STAT_ADDR)) begin
      next_rdata = {6'h00, rif[1].fault, rif[0].fault};
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Read data and pin history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      exit_pin_q <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : reg_rdata;
      exit_pin_q <= standby_exit_pin;
    end
  end

  // Level select; reserved codes are stored and give 1.5 V while gps_core_rail_1v3 is low
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      level_1v5 <= `LEVEL_RESET;
      rail_1v5_level_1v6 <= 1'b0;
    end else begin
      level_1v5 <= wr_1v5 ? reg_wdata[`LEVEL_MSB:`LEVEL_LSB] : level_1v5;
      rail_1v5_level_1v6 <= (level_1v5 == `LEVEL_1V6_CODE)
                            || gps_core_rail_1v3;
    end
  end

  // Latest current sample of each rail
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      current_2v1 <= 8'h00;
      current_1v5 <= 8'h00;
    end else begin
      if (adc_valid && !adc_rail) begin
        current_2v1 <= adc_data;
      end
      if (adc_valid && adc_rail) begin
        current_1v5 <= adc_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_irq_or;
    @(posedge clk) disable iff (!nrst)
      regulator_fault_irq ==
        (rail_2v1_overcurrent_flag || rail_1v5_overcurrent_flag);
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("fault interrupt does not follow the flags");

  property p_gps_force;
    @(posedge clk) disable iff (!nrst)
      gps_core_rail_1v3 |=> rail_1v5_level_1v6;
  endproperty
  a_gps_force: assert property (p_gps_force)
    else $error("1.5 V rail not raised for GPS core at 1.3 V");

  property p_level_write;
    @(posedge clk) disable iff (!nrst)
      (wr_1v5 && reg_wdata[7:6] == 2'h1) |=> ##1 rail_1v5_level_1v6;
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("level code 1 did not select 1.6 V");

  property p_rd_2v1;
    @(posedge clk) disable iff (!nrst)
      (reg_rd && reg_addr == 8'h38)
        |=> reg_rdata == {2'h0, $past(rif[0].exit_mode),
                          $past(rail_2v1_run_mode)};
  endproperty
  a_rd_2v1: assert property (p_rd_2v1)
    else $error("2.1 V control readback wrong");

  property p_adc_store;
    @(posedge clk) disable iff (!nrst)
      (adc_valid && !adc_rail) |=> current_2v1 == $past(adc_data);
  endproperty
  a_adc_store: assert property (p_adc_store)
    else $error("2.1 V current sample not stored");

  // A status read clears the flag only when no new over-current arrives
  property p_fault_clr;
    @(posedge clk) disable iff (!nrst)
      (rd_stat && !overcurrent_2v1) |=> !rail_2v1_overcurrent_flag;
  endproperty
  a_fault_clr: assert property (p_fault_clr)
    else $error("status read did not clear the 2.1 V flag");

  property p_fault_1v5;
    @(posedge clk) disable iff (!nrst)
      overcurrent_1v5 |=> (rail_1v5_overcurrent_flag && regulator_fault_irq);
  endproperty
  a_fault_1v5: assert property (p_fault_1v5)
    else $error("1.5 V over-current did not raise flag and interrupt");

endmodule : buck_rail_mode_control

// >>> verif/rail_sense_model.sv
// System pins, over-current sense and ADC results seen by the buck block
module rail_sense_model
  import buck_rail_pkg::*;
(
  // Clock
  input wire logic clk,
  // System and analog side
  output logic standby_exit_pin,
  output logic overcurrent_2v1,
  output logic overcurrent_1v5,
  output logic adc_valid,
  output logic adc_rail,
  output buck_rail_pkg::reg_t adc_data
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial begin
    standby_exit_pin = 1'b0;
    overcurrent_2v1 = 1'b0;
    overcurrent_1v5 = 1'b0;
    adc_valid = 1'b0;
    adc_rail = 1'b0;
    adc_data = 8'h00;
  end

  // Pin stays high two edges, then is driven low on the third edge and the task returns at once
  task automatic exit_pulse();
    @(posedge clk);
    standby_exit_pin <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    standby_exit_pin <= 1'b0;
  endtask : exit_pulse

  // One-cycle over-current on the chosen rail
  task automatic oc_pulse(input logic rail);
    @(posedge clk);
    overcurrent_2v1 <= !rail;
    overcurrent_1v5 <= rail;
    @(posedge clk);
    overcurrent_2v1 <= 1'b0;
    overcurrent_1v5 <= 1'b0;
  endtask : oc_pulse

  // Data is scrambled after the strobe so a stale value cannot pass
  task automatic adc_push(input logic rail, input reg_t data);
    @(posedge clk);
    adc_valid <= 1'b1;
    adc_rail <= rail;
    adc_data <= data;
    @(posedge clk);
    adc_valid <= 1'b0;
    adc_data <= ~data;
  endtask : adc_push
endmodule : rail_sense_model

// >>> verif/buck_rail_mode_control_tb.sv
// Self-checking bench for the two-rail buck mode control
`include "buck_rail_map.svh"
module buck_rail_mode_control_tb import buck_rail_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic gps_core_rail_1v3 = 1'b0;
  reg_t reg_addr = 8'h00;
  reg_t reg_wdata = 8'h00;
  reg_t reg_rdata;
  reg_t adc_data;
  logic standby_exit_pin, overcurrent_2v1, overcurrent_1v5;
  logic adc_valid, adc_rail, rail_1v5_level_1v6;
  logic discharge_2v1, discharge_1v5, regulator_fault_irq;
  logic rail_2v1_overcurrent_flag, rail_1v5_overcurrent_flag;
  mode_t rail_2v1_run_mode, rail_1v5_run_mode;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #25 clk = ~clk;

  buck_rail_mode_control DUT (.clk(clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .standby_exit_pin(standby_exit_pin),
    .gps_core_rail_1v3(gps_core_rail_1v3),
    .overcurrent_2v1(overcurrent_2v1), .overcurrent_1v5(overcurrent_1v5),
    .adc_valid(adc_valid), .adc_rail(adc_rail), .adc_data(adc_data),
    .rail_2v1_run_mode(rail_2v1_run_mode),
    .rail_1v5_run_mode(rail_1v5_run_mode),
    .rail_1v5_level_1v6(rail_1v5_level_1v6),
    .discharge_2v1(discharge_2v1), .discharge_1v5(discharge_1v5),
    .rail_2v1_overcurrent_flag(rail_2v1_overcurrent_flag),
    .rail_1v5_overcurrent_flag(rail_1v5_overcurrent_flag),
    .regulator_fault_irq(regulator_fault_irq));

  rail_sense_model env (.clk(clk), .standby_exit_pin(standby_exit_pin),
    .overcurrent_2v1(overcurrent_2v1), .overcurrent_1v5(overcurrent_1v5),
    .adc_valid(adc_valid), .adc_rail(adc_rail), .adc_data(adc_data));

  // ----------------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input reg_t seen, input reg_t exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Strobe held until the taking edge, dropped by that same edge
  task automatic wr(input reg_t a, input reg_t d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data is registered, so it is checked half a cycle later
  task automatic rd(input reg_t a, input reg_t exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(what, reg_rdata, exp);
  endtask : rd

  task automatic stop_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // Whole sequence needs about a hundred cycles; this cuts a hang
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("run_2v1", {5'h0, rail_2v1_run_mode}, 8'h07);
    chk("run_1v5", {5'h0, rail_1v5_run_mode}, 8'h07);
    chk("irq", {7'h0, regulator_fault_irq}, 8'h00);
    rd(`RAIL_2V1_CTRL_ADDR, 8'h07, "ctrl_2v1");
    rd(`RAIL_1V5_CTRL_ADDR, 8'h07, "ctrl_1v5");
    rd(8'h40, 8'h00, "unmapped");
    // Every run code on both rails; only off discharges
    for (int m = 4; m < 8; m++) begin
      wr(`RAIL_2V1_CTRL_ADDR, 8'(m));
      wr(`RAIL_1V5_CTRL_ADDR, 8'(m));
      @(negedge clk);
      chk("run_2v1", {5'h0, rail_2v1_run_mode}, 8'(m));
      chk("run_1v5", {5'h0, rail_1v5_run_mode}, 8'(m));
      chk("dis_2v1", {7'h0, discharge_2v1}, {7'h0, m == 4});
      chk("dis_1v5", {7'h0, discharge_1v5}, {7'h0, m == 4});
    end
    // Reserved bits drop out; a reserved run code keeps the mode
    wr(`RAIL_2V1_CTRL_ADDR, 8'hc5);
    rd(`RAIL_2V1_CTRL_ADDR, 8'h05, "rsvd_bits");
    wr(`RAIL_2V1_CTRL_ADDR, 8'h02);
    @(negedge clk);
    chk("run_hold", {5'h0, rail_2v1_run_mode}, 8'h05);
    // Standby exit copies only the valid exit codes
    wr(`RAIL_2V1_CTRL_ADDR, 8'h27);
    wr(`RAIL_1V5_CTRL_ADDR, 8'h2e);
    env.exit_pulse();
    @(negedge clk);
    chk("exit_2v1", {5'h0, rail_2v1_run_mode}, 8'h04);
    chk("exit_dis", {7'h0, discharge_2v1}, 8'h01);
    chk("exit_1v5", {5'h0, rail_1v5_run_mode}, 8'h05);
    wr(`RAIL_2V1_CTRL_ADDR, 8'h17);
    wr(`RAIL_1V5_CTRL_ADDR, 8'h0e);
    env.exit_pulse();
    @(negedge clk);
    chk("nocopy_2v1", {5'h0, rail_2v1_run_mode}, 8'h07);
    chk("nocopy_1v5", {5'h0, rail_1v5_run_mode}, 8'h06);
    // Over-current on each rail, cleared by the status read
    for (int r = 0; r < 2; r++) begin
      env.oc_pulse(r[0]);
      @(negedge clk);
      chk("flag_2v1", {7'h0, rail_2v1_overcurrent_flag}, 8'(r == 0));
      chk("flag_1v5", {7'h0, rail_1v5_overcurrent_flag}, 8'(r == 1));
      chk("irq_set", {7'h0, regulator_fault_irq}, 8'h01);
      rd(`FAULT_STAT_ADDR, 8'(r + 1), "fault_stat");
      chk("irq_clr", {7'h0, regulator_fault_irq}, 8'h00);
    end
    // Over-current in the same cycle as the status read: the set wins
    fork
      env.oc_pulse(1'b0);
      rd(`FAULT_STAT_ADDR, 8'h00, "stat_race");
    join
    chk("flag_race", {7'h0, rail_2v1_overcurrent_flag}, 8'h01);
    rd(`FAULT_STAT_ADDR, 8'h01, "stat_after");
    chk("irq_after", {7'h0, regulator_fault_irq}, 8'h00);
    // Current results land in read-only registers
    env.adc_push(1'b0, 8'h5a);
    env.adc_push(1'b1, 8'ha5);
    wr(`RAIL_2V1_CUR_ADDR, 8'h00);
    rd(`RAIL_2V1_CUR_ADDR, 8'h5a, "cur_2v1");
    rd(`RAIL_1V5_CUR_ADDR, 8'ha5, "cur_1v5");
    // Level select, then forcing from the GPS core rail
    wr(`RAIL_1V5_CTRL_ADDR, 8'h47);
    @(posedge clk);
    @(negedge clk);
    chk("lvl_1v6", {7'h0, rail_1v5_level_1v6}, 8'h01);
    wr(`RAIL_1V5_CTRL_ADDR, 8'h87);
    @(posedge clk);
    @(negedge clk);
    chk("lvl_rsvd", {7'h0, rail_1v5_level_1v6}, 8'h00);
    @(posedge clk);
    gps_core_rail_1v3 <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("lvl_gps", {7'h0, rail_1v5_level_1v6}, 8'h01);
    rd(`RAIL_1V5_CTRL_ADDR, 8'h87, "ctrl_1v5");
    stop_test();
  end
endmodule : buck_rail_mode_control_tb
